// ---- rtl/hsr_pkg.sv ----
// Purpose: Shared constants and types for the 3-axis Hall sensor readout.
// Assumes: Core clock of 40 ns period; results are 12-bit two's complement.
// Notes: Period counts above 4096 cycles are overridable at the top level.
package hsr_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int INT_MIN_NS = 1500;
   localparam int INT_CYC = (INT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STRAP_NS = 260_000;
   localparam int STRAP_CYC = STRAP_NS / CLK_PERIOD_NS;
   localparam int BIAS_NS = 2_000;
   localparam int BIAS_CYC = BIAS_NS / CLK_PERIOD_NS;
   localparam int FSM_PERIOD_NS = 303_030;
   localparam int FSM_PERIOD_CYC = FSM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int LPM_PERIOD_NS = 12_004_801;
   localparam int LPM_PERIOD_CYC = LPM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int ULPM_PERIOD_NS = 100_000_000;
   localparam int ULPM_PERIOD_CYC = ULPM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TMR_W = 22;
   localparam int INT_W = 6;
   localparam int RES_W = 12;
   localparam int THR_W = 11;
   localparam int N_RD = 7;
   localparam int N_WR = 4;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Write register indices and bit positions.
   localparam logic [1:0] W_MOD1 = 2'h1;
   localparam logic [1:0] W_LP = 2'h3;
   localparam int MOD1_LOW = 0;
   localparam int MOD1_FAST = 1;
   localparam int MOD1_INT = 2;
   localparam int LP_BIT = 6;
   localparam logic [7:0] WR_RESET = 8'h00;
   // Slave addresses; the alternate one is selected by a low strap.
   localparam logic [6:0] DEF_ADDR = 7'h5E;
   localparam logic [6:0] ALT_ADDR = 7'h1E;
   localparam logic [7:0] GC_BYTE = 8'h00;
   // Converter channel order.
   localparam logic [1:0] CH_TEMP = 2'h0;
   localparam logic [1:0] CH_Z = 2'h3;
   typedef enum logic [2:0] {M_PDM, M_FSM, M_LPM, M_ULPM, M_MCM} hsr_mode_t;
   typedef enum logic [2:0] {C_PDM, C_QUAL, C_BIAS, C_CONV, C_SLEEP}
      hsr_core_st_t;
   typedef enum logic [2:0] {L_IDLE, L_ADDR, L_WDATA, L_RDATA, L_SKIP}
      hsr_link_st_t;
endpackage

// ---- rtl/hsr_top.sv ----
// Purpose: Digital core of a 3-axis Hall sensor with an I2C slave port.
// Assumes: link_clk oversamples SCL and SDA; ADC handshake is on clk.
// Notes: Open-drain pins appear as input, output and enable.
// Functional notes
// RULE_01: Convert temperature, then X, Y, Z.
// RULE_02: Power-up lands in power-down, no conversions.
// RULE_03: Operating mode repeats qualify, bias, measure, return.
// RULE_04: Undervoltage holds sequencer until supply recovers.
// RULE_05: Out-of-window axis pulses interrupt when enabled.
// RULE_06: Wake interrupt ORs the three axis windows.
// RULE_07: Interrupt may be inhibited during bus activity.
// RULE_08: Threshold level is 11-bit field times two.
// RULE_09: Axis results signed 12-bit, one gauss each.
// RULE_10: Short reading is upper eight result bits.
// RULE_11: Temperature split over registers three and six.
// RULE_12: Temperature code reads as degrees Celsius.
// RULE_13: Device is slave only; master frames transfers.
// RULE_14: MSB first; data always starts at register zero.
// RULE_15: Port answers in every power mode.
// RULE_16: Reset loads defaults; results read zero.
// RULE_17: Undervoltage restarts conversion; deep undervoltage resets.
// RULE_18: General-call address forces a full reset.
// RULE_19: Two-bit frame counter counts completed cycles.
// RULE_20: Full write 45 bits, full read 81 bits; with seven read registers a full read here is 72 bits.
// RULE_21: Interrupt is driven on the clock pin.
// RULE_22: Port runs at 400 kbit/s up to 1 Mbit/s.
// RULE_23: Data line held high at start-up.
// RULE_24: Data line strap picks the slave address.
// RULE_25: Configuration applies after all four bytes written.
// RULE_26: Interrupt pulse is low for the minimum width.
// RULE_27: Both mode bits zero selects power-down.
// RULE_28: Read pointer advances after each acknowledged byte.
`timescale 1ns/10ps
`default_nettype none
module hsr_top
   import hsr_pkg::*;
#(
   parameter int unsigned STRAP_CYCLES = STRAP_CYC,
   parameter int unsigned FSM_CYCLES = FSM_PERIOD_CYC,
   parameter int unsigned LPM_CYCLES = LPM_PERIOD_CYC,
   parameter int unsigned ULPM_CYCLES = ULPM_PERIOD_CYC
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   // Bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Supply monitor pins
   input wire logic supply_ok,
   input wire logic supply_deep_low,
   // Converter handshake
   output logic adc_start,
   output logic [1:0] adc_chan,
   input wire logic adc_done,
   input wire logic [RES_W-1:0] adc_data,
   // Wake-up configuration and status
   input wire logic wake_en,
   input wire logic int_inhibit_en,
   input wire logic [2:0][THR_W-1:0] axis_window_thresholds_lo,
   input wire logic [2:0][THR_W-1:0] axis_window_thresholds_hi,
   output logic [1:0] frame_count
);
   logic [1:0] sda_c_q, uv_q, duv_q, busy_c_q;
   logic [2:0] cfg_t_q, gc_t_q, rdd_t_q, pub_t_q;
   logic [1:0] scl_l_q, sda_l_q, strap_l_q, alt_l_q;
   logic scl_p_q, sda_p_q;
   logic uv_ok, srst, srst_q, cfg_evt, rdd_evt, busy_c;
   logic [TMR_W-1:0] strap_cnt_q, tmr_q, period;
   logic strap_done_q, addr_alt_q;
   logic [7:0] mod1_q, lp_q;
   hsr_mode_t mode;
   hsr_core_st_t st_q;
   logic adc_start_q, commit, commit_q, pub_tgl_q;
   logic [1:0] adc_chan_q, frame_q;
   logic [3:0][RES_W-1:0] stage_q, res_q;
   logic [2:0] out_w;
   logic wake_evt, eoc_evt, int_oe_q;
   logic [INT_W-1:0] int_tmr_q, int_len_q;
   logic [N_RD-1:0][7:0] rd_pub_q, snap_q;
   hsr_link_st_t l_st_q;
   logic scl, sda, start, stop, rise, fall, pend_q;
   logic [3:0] cnt_q;
   logic ack_q, busy_q, cfg_tgl_q, gc_tgl_q, rdd_tgl_q, rd_any_q;
   logic l_sda_oe_q;
   logic [7:0] sh_q, tx_q, rbyte;
   logic [2:0] ptr_q, wcnt_q;
   logic [N_WR-1:0][7:0] wbuf_q, cfg_x_q;
   logic [6:0] my_addr;

   // Core-domain synchronisers; edges use the second and third stages.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_c_q <= '0;
         uv_q <= '0;
         duv_q <= '0;
         busy_c_q <= '0;
         cfg_t_q <= '0;
         gc_t_q <= '0;
         rdd_t_q <= '0;
      end else begin
         sda_c_q <= {sda_c_q[0], sda_i};
         uv_q <= {uv_q[0], supply_ok};
         duv_q <= {duv_q[0], supply_deep_low};
         busy_c_q <= {busy_c_q[0], busy_q};
         cfg_t_q <= {cfg_t_q[1:0], cfg_tgl_q};
         gc_t_q <= {gc_t_q[1:0], gc_tgl_q};
         rdd_t_q <= {rdd_t_q[1:0], rdd_tgl_q};
      end
   end
   assign uv_ok = uv_q[1];
   assign busy_c = busy_c_q[1];
   assign cfg_evt = cfg_t_q[2] ^ cfg_t_q[1];
   assign rdd_evt = rdd_t_q[2] ^ rdd_t_q[1];
   assign srst = (gc_t_q[2] ^ gc_t_q[1]) | duv_q[1]; // RULE_17 RULE_18

   // The address strap is caught after reset release, never at reset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_cnt_q <= '0;
         strap_done_q <= 1'b0;
         addr_alt_q <= 1'b0;
      end else if (!strap_done_q) begin
         addr_alt_q <= ~sda_c_q[1]; // RULE_24
         if (strap_cnt_q == TMR_W'(STRAP_CYCLES - 1)) begin
            strap_done_q <= 1'b1;
         end else begin
            strap_cnt_q <= strap_cnt_q + 1'b1;
         end
      end
   end

   // Configuration only moves on a completed four-byte write or on a soft reset (srst).
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mod1_q <= WR_RESET; // RULE_02 RULE_16
         lp_q <= WR_RESET;
      end else if (srst) begin
         mod1_q <= WR_RESET;
         lp_q <= WR_RESET;
      end else if (cfg_evt) begin
         mod1_q <= cfg_x_q[W_MOD1]; // RULE_25
         lp_q <= cfg_x_q[W_LP];
      end
   end

   always_comb begin
      unique case ({mod1_q[MOD1_FAST], mod1_q[MOD1_LOW]})
         2'b00: mode = M_PDM; // RULE_27
         2'b10: mode = M_FSM;
         2'b01: mode = lp_q[LP_BIT] ? M_LPM : M_ULPM;
         2'b11: mode = M_MCM;
      endcase
      unique case (mode)
         M_FSM: period = TMR_W'(FSM_CYCLES);
         M_LPM: period = TMR_W'(LPM_CYCLES);
         default: period = TMR_W'(ULPM_CYCLES);
      endcase
   end

   assign commit = st_q == C_CONV && uv_ok && adc_done && adc_chan_q == CH_Z;

   // Measurement sequencer.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= C_PDM; // RULE_02
         tmr_q <= '0;
         adc_chan_q <= CH_TEMP;
         adc_start_q <= 1'b0;
      end else begin
         adc_start_q <= 1'b0;
         if (srst) begin
            st_q <= C_PDM;
         end else begin
            unique case (st_q)
               C_PDM: if (mode != M_PDM) st_q <= C_QUAL;
               C_QUAL: begin
                  if (mode == M_PDM) begin
                     st_q <= C_PDM;
                  end else if (uv_ok) begin // RULE_03 RULE_04
                     st_q <= C_BIAS;
                     tmr_q <= TMR_W'(BIAS_CYC);
                  end
               end
               C_BIAS: begin
                  if (!uv_ok) begin
                     st_q <= C_QUAL;
                  end else if (tmr_q == '0) begin
                     st_q <= C_CONV;
                     adc_chan_q <= CH_TEMP; // RULE_01
                     adc_start_q <= 1'b1;
                  end else begin
                     tmr_q <= tmr_q - 1'b1;
                  end
               end
               C_CONV: begin
                  if (!uv_ok) begin
                     st_q <= C_QUAL; // RULE_17
                  end else if (adc_done) begin
                     if (adc_chan_q == CH_Z) begin
                        st_q <= C_SLEEP; // RULE_03
                        tmr_q <= period;
                     end else begin
                        adc_chan_q <= adc_chan_q + 1'b1; // RULE_01
                        adc_start_q <= 1'b1;
                     end
                  end
               end
               C_SLEEP: begin
                  if (mode == M_PDM) begin
                     st_q <= C_PDM;
                  end else if (mode == M_MCM) begin
                     if (rdd_evt) st_q <= C_QUAL;
                  end else if (tmr_q == '0) begin
                     st_q <= C_QUAL;
                  end else begin
                     tmr_q <= tmr_q - 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Results are staged so an aborted cycle leaves registers intact.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage_q <= '0; // RULE_16
         res_q <= '0;
         frame_q <= '0;
         commit_q <= 1'b0;
         srst_q <= 1'b0;
      end else begin
         commit_q <= commit && !srst;
         srst_q <= srst;
         if (srst) begin
            stage_q <= '0;
            res_q <= '0;
            frame_q <= '0;
         end else begin
            if (st_q == C_CONV && uv_ok && adc_done) begin
               stage_q[adc_chan_q] <= adc_data; // RULE_09 RULE_12
            end
            if (commit) begin
               res_q <= {adc_data, stage_q[2:0]};
               frame_q <= frame_q + 1'b1; // RULE_19
            end
         end
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_win
      assign out_w[g] = // RULE_08
         ($signed(res_q[g+1]) < $signed({axis_window_thresholds_lo[g], 1'b0}))
         || ($signed(res_q[g+1]) >
            $signed({axis_window_thresholds_hi[g], 1'b0}));
   end
   assign wake_evt = commit_q && wake_en && |out_w; // RULE_05 RULE_06
   assign eoc_evt = commit_q && mod1_q[MOD1_INT];

   // Interrupt pulls the clock pin low; it is dropped, not delayed, when
   // inhibited, so a late pulse can never land inside a transfer.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_oe_q <= 1'b0;
         int_tmr_q <= '0;
         int_len_q <= '0;
      end else begin
         int_len_q <= int_oe_q ? int_len_q + 1'b1 : '0;
         if ((wake_evt || eoc_evt) && !(int_inhibit_en && busy_c) // RULE_07
             && int_tmr_q == '0) begin
            int_oe_q <= 1'b1; // RULE_21
            int_tmr_q <= INT_W'(INT_CYC - 1); // RULE_26
         end else if (int_tmr_q != '0) begin
            int_tmr_q <= int_tmr_q - 1'b1;
         end else begin
            int_oe_q <= 1'b0;
         end
      end
   end

   // Read image is published with a toggle and held stable for the link.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_pub_q <= '0;
         pub_tgl_q <= 1'b0;
      end else if (commit_q || srst_q) begin
         pub_tgl_q <= ~pub_tgl_q;
         rd_pub_q[0] <= res_q[1][RES_W-1 -: 8]; // RULE_10
         rd_pub_q[1] <= res_q[2][RES_W-1 -: 8];
         rd_pub_q[2] <= res_q[3][RES_W-1 -: 8];
         rd_pub_q[3] <= res_q[0][RES_W-1 -: 8]; // RULE_11
         rd_pub_q[4] <= {res_q[1][3:0], res_q[2][3:0]};
         rd_pub_q[5] <= {res_q[3][3:0], 2'h0, frame_q};
         rd_pub_q[6] <= {4'h0, res_q[0][3:0]};
      end
   end

   assign adc_start = adc_start_q;
   assign adc_chan = adc_chan_q;
   assign frame_count = frame_q;
   assign scl_o = 1'b0;
   assign scl_oe = int_oe_q;
   assign sda_o = 1'b0;
   assign sda_oe = l_sda_oe_q;

   // Link domain: 8 samples per bit keeps margin up to 1 Mbit/s.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         scl_l_q <= 2'h3;
         sda_l_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         strap_l_q <= '0;
         alt_l_q <= '0;
         pub_t_q <= '0;
      end else begin
         scl_l_q <= {scl_l_q[0], scl_i}; // RULE_22
         sda_l_q <= {sda_l_q[0], sda_i};
         scl_p_q <= scl_l_q[1];
         sda_p_q <= sda_l_q[1];
         strap_l_q <= {strap_l_q[0], strap_done_q};
         alt_l_q <= {alt_l_q[0], addr_alt_q};
         pub_t_q <= {pub_t_q[1:0], pub_tgl_q};
      end
   end
   assign scl = scl_l_q[1];
   assign sda = sda_l_q[1];
   assign start = scl && scl_p_q && sda_p_q && !sda;
   assign stop = scl && scl_p_q && !sda_p_q && sda;
   assign rise = scl && !scl_p_q;
   assign fall = !scl && scl_p_q;
   assign my_addr = alt_l_q[1] ? ALT_ADDR : DEF_ADDR;
   assign rbyte = (ptr_q < 3'(N_RD)) ? snap_q[ptr_q] : 8'h00;

   // A snapshot never changes under an ongoing read.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         snap_q <= '0;
         pend_q <= 1'b0;
      end else begin
         if (pub_t_q[2] ^ pub_t_q[1]) pend_q <= 1'b1;
         if (pend_q && l_st_q != L_RDATA) begin
            snap_q <= rd_pub_q;
            pend_q <= 1'b0;
         end
      end
   end

   // Slave engine; no power-mode term gates it.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         l_st_q <= L_IDLE;
         cnt_q <= '0;
         ack_q <= 1'b0;
         sh_q <= '0;
         tx_q <= '0;
         ptr_q <= '0;
         wcnt_q <= '0;
         wbuf_q <= '0;
         cfg_x_q <= '0;
         l_sda_oe_q <= 1'b0;
         busy_q <= 1'b0;
         cfg_tgl_q <= 1'b0;
         gc_tgl_q <= 1'b0;
         rdd_tgl_q <= 1'b0;
         rd_any_q <= 1'b0;
      end else if (start) begin
         l_st_q <= L_ADDR; // RULE_13 RULE_15
         cnt_q <= '0;
         ack_q <= 1'b0;
         l_sda_oe_q <= 1'b0;
         ptr_q <= '0; // RULE_14
         wcnt_q <= '0;
         busy_q <= 1'b1;
         rd_any_q <= 1'b0;
      end else if (stop) begin
         l_st_q <= L_IDLE;
         l_sda_oe_q <= 1'b0;
         busy_q <= 1'b0;
         if (wcnt_q == 3'(N_WR)) begin
            cfg_x_q <= wbuf_q; // RULE_25
            cfg_tgl_q <= ~cfg_tgl_q;
         end
         if (rd_any_q) rdd_tgl_q <= ~rdd_tgl_q;
      end else if (rise && l_st_q != L_IDLE) begin
         if (!ack_q) begin
            sh_q <= {sh_q[6:0], sda}; // RULE_14
            cnt_q <= cnt_q + 1'b1;
         end else if (l_st_q == L_RDATA && sda) begin
            l_st_q <= L_SKIP;
         end
      end else if (fall && l_st_q != L_IDLE) begin
         if (ack_q) begin
            ack_q <= 1'b0;
            cnt_q <= '0;
            l_sda_oe_q <= 1'b0;
            if (l_st_q == L_RDATA) begin
               tx_q <= rbyte;
               l_sda_oe_q <= ~rbyte[7];
            end
         end else if (cnt_q == BYTE_BITS) begin
            ack_q <= 1'b1;
            unique case (l_st_q)
               L_ADDR: begin
                  if (sh_q[7:1] == my_addr && strap_l_q[1]) begin
                     l_sda_oe_q <= 1'b1;
                     l_st_q <= sh_q[0] ? L_RDATA : L_WDATA;
                  end else if (sh_q == GC_BYTE) begin
                     l_sda_oe_q <= 1'b1;
                     gc_tgl_q <= ~gc_tgl_q; // RULE_18
                     l_st_q <= L_SKIP;
                  end else begin
                     l_st_q <= L_SKIP;
                  end
               end
               L_WDATA: begin
                  l_sda_oe_q <= 1'b1;
                  if (wcnt_q < 3'(N_WR)) begin
                     wbuf_q[wcnt_q[1:0]] <= sh_q;
                     wcnt_q <= wcnt_q + 1'b1;
                  end
               end
               L_RDATA: begin
                  l_sda_oe_q <= 1'b0;
                  // Saturates past the last register so long reads give zero.
                  ptr_q <= ptr_q + {2'h0, ptr_q < 3'(N_RD)}; // RULE_28
                  rd_any_q <= 1'b1;
               end
               L_IDLE, L_SKIP: ;
            endcase
         end else if (l_st_q == L_RDATA) begin
            tx_q <= {tx_q[6:0], 1'b0};
            l_sda_oe_q <= ~tx_q[6];
         end
      end
   end

   property p_temp_first;
      @(posedge clk) disable iff (rst)
      st_q == C_BIAS && uv_ok && tmr_q == '0 && !srst
      |=> adc_start_q && adc_chan_q == CH_TEMP && st_q == C_CONV;
   endproperty
   a_temp_first: assert property (p_temp_first) // RULE_01
      else $error("Cycle did not open on temperature.");
   property p_chan_next;
      @(posedge clk) disable iff (rst)
      st_q == C_CONV && uv_ok && adc_done && adc_chan_q != CH_Z && !srst
      |=> adc_start_q && adc_chan_q == $past(adc_chan_q) + 2'h1;
   endproperty
   a_chan_next: assert property (p_chan_next) // RULE_01
      else $error("Channel order broken.");
   property p_pdm_idle;
      @(posedge clk) disable iff (rst)
      st_q == C_PDM && mode == M_PDM |=> st_q == C_PDM && !adc_start_q;
   endproperty
   a_pdm_idle: assert property (p_pdm_idle) // RULE_02
      else $error("Conversion started in power-down.");
   property p_uv_hold;
      @(posedge clk) disable iff (rst)
      st_q == C_QUAL && !uv_ok && !srst |=> st_q == C_QUAL && !adc_start_q;
   endproperty
   a_uv_hold: assert property (p_uv_hold) // RULE_04
      else $error("Sequencer ran below the supply level.");
   property p_uv_abort;
      @(posedge clk) disable iff (rst)
      st_q == C_CONV && !uv_ok && !srst
      |=> st_q == C_QUAL ##1 res_q == $past(res_q, 2);
   endproperty
   a_uv_abort: assert property (p_uv_abort) // RULE_17
      else $error("Undervoltage abort lost or changed results.");
   property p_frame;
      @(posedge clk) disable iff (rst)
      commit && !srst |=> frame_q == $past(frame_q) + 2'h1;
   endproperty
   a_frame: assert property (p_frame) // RULE_19
      else $error("Frame counter did not advance.");
   property p_wake;
      @(posedge clk) disable iff (rst)
      wake_evt && !(int_inhibit_en && busy_c) && int_tmr_q == '0
      |=> int_oe_q ##1 int_oe_q;
   endproperty
   a_wake: assert property (p_wake) // RULE_05
      else $error("Out-of-window result gave no pulse.");
   property p_quiet;
      @(posedge clk) disable iff (rst)
      commit_q && !mod1_q[MOD1_INT] && !(wake_en && |out_w) && !int_oe_q
      |=> !int_oe_q;
   endproperty
   a_quiet: assert property (p_quiet) // RULE_06
      else $error("Pulse given with all axes inside.");
   property p_int_len;
      @(posedge clk) disable iff (rst)
      $fell(int_oe_q) |-> int_len_q == INT_W'(INT_CYC);
   endproperty
   a_int_len: assert property (p_int_len) // RULE_26
      else $error("Interrupt pulse has wrong width.");
   property p_inhibit;
      @(posedge clk) disable iff (rst)
      int_inhibit_en && busy_c && !int_oe_q |=> !int_oe_q;
   endproperty
   a_inhibit: assert property (p_inhibit) // RULE_07
      else $error("Interrupt raised during a transfer.");
   property p_start_ptr;
      @(posedge link_clk) disable iff (rst)
      start |=> ptr_q == '0 && l_st_q == L_ADDR && !l_sda_oe_q;
   endproperty
   a_start_ptr: assert property (p_start_ptr) // RULE_14
      else $error("Transfer did not restart at register zero.");
   property p_cfg_all;
      @(posedge link_clk) disable iff (rst)
      stop && wcnt_q != 3'(N_WR) |=> $stable(cfg_tgl_q);
   endproperty
   a_cfg_all: assert property (p_cfg_all) // RULE_25
      else $error("Partial write changed configuration.");
endmodule
`default_nettype wire

// ---- tb/hsr_i2c_master.sv ----
// Purpose: Bus master model that frames transfers on the two-wire port.
// Assumes: Lines have pull-ups; a high output pulls its line low.
// Notes: 400 kbit/s; waits before a start while the interrupt holds the clock line low.
`timescale 1ns/10ps
`default_nettype none
module hsr_i2c_master #(
   parameter int HALF_NS = 1250
) (
   // Open-drain pulls
   output logic scl_dn,
   output logic sda_dn,
   // Resolved lines
   input wire logic scl,
   input wire logic sda
);
   // Both lines released from time zero, so the strap reads high.
   initial begin
      scl_dn = 1'b0;
      sda_dn = 1'b0;
   end
   task automatic start();
      wait (scl === 1'b1);
      sda_dn = 1'b1;
      #(HALF_NS);
      scl_dn = 1'b1;
   endtask
   task automatic xfer(input logic b, output logic r);
      sda_dn = ~b;
      #(HALF_NS);
      scl_dn = 1'b0;
      #(HALF_NS);
      r = sda;
      scl_dn = 1'b1;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic ai,
      output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) xfer(d[i], q[i]);
      xfer(ai, ack);
   endtask
   task automatic stop();
      sda_dn = 1'b1;
      #(HALF_NS);
      scl_dn = 1'b0;
      #(HALF_NS);
      sda_dn = 1'b0;
      #(HALF_NS);
   endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the Hall sensor readout core.
// Assumes: Short parameter values; converter model answers in 5 clocks.
// Notes: Master-controlled mode keeps the frame count predictable.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
   $display("Error %s expected %0h seen %0h", nm, e, s); end end
module testbench;
   import hsr_pkg::*;
   logic clk = 0, rst = 1, link_clk = 0, adc_done = 0, wake_en = 0;
   logic supply_ok = 1, supply_deep_low = 0, int_inhibit_en = 0;
   logic [RES_W-1:0] adc_data = '0;
   logic [2:0][THR_W-1:0] thr_lo = '0, thr_hi = '0;
   wire logic scl_o, scl_oe, sda_o, sda_oe, adc_start, m_scl, m_sda;
   wire logic [1:0] adc_chan, frame_count;
   wire logic scl = ~(m_scl | (scl_oe & ~scl_o));
   wire logic sda = ~(m_sda | (sda_oe & ~sda_o));
   int errors = 0, n_tests = 0, n_int = 0, int_w = 0, n_start = 0;
   int adc_wait = 0;
   logic [1:0] exp_ch = 2'h0;
   logic [RES_W-1:0] adc_tab [4] = '{12'h06A, 12'hF0F, 12'h4D0, 12'h123};
   always #20 clk = ~clk;
   always #62.5 link_clk = ~link_clk;
   hsr_top #(.STRAP_CYCLES(20), .FSM_CYCLES(60), .LPM_CYCLES(100),
      .ULPM_CYCLES(150)) i_hsr_top (.clk(clk), .rst(rst),
      .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .supply_ok(supply_ok),
      .supply_deep_low(supply_deep_low), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
      .wake_en(wake_en), .int_inhibit_en(int_inhibit_en),
      .axis_window_thresholds_lo(thr_lo), .axis_window_thresholds_hi(thr_hi),
      .frame_count(frame_count));
   hsr_i2c_master i_hsr_i2c_master (.scl_dn(m_scl), .sda_dn(m_sda),
      .scl(scl), .sda(sda));
   always @(negedge clk) begin
      adc_done <= (adc_wait == 1);
      adc_data <= adc_tab[adc_chan];
      adc_wait <= (adc_start === 1'b1) ? 5 : (adc_wait > 0) ? adc_wait - 1 : 0;
      if (adc_start === 1'b1) begin
         `CHK("adc_chan", exp_ch, adc_chan)
         exp_ch <= exp_ch + 2'h1;
         n_start <= n_start + 1;
      end else if (!supply_ok) begin
         exp_ch <= 2'h0;
      end
      if (scl_oe === 1'b1) begin
         `CHK("scl level", 1'b0, scl)
         int_w <= int_w + 1;
      end else if (int_w > 0) begin
         `CHK("int width", 1'b1, int_w >= INT_CYC)
         n_int <= n_int + 1;
         int_w <= 0;
      end
   end
   function automatic logic [63:0] img(input logic [1:0] f);
      img = {adc_tab[1][11:4], adc_tab[2][11:4], adc_tab[3][11:4],
         adc_tab[0][11:4], adc_tab[1][3:0], adc_tab[2][3:0],
         adc_tab[3][3:0], 2'b00, f, 4'h0, adc_tab[0][3:0], 8'h00};
   endfunction
   task automatic wr(input logic [6:0] a, input logic [31:0] d, input int n);
      logic [7:0] q;
      logic ack;
      i_hsr_i2c_master.start();
      i_hsr_i2c_master.byte_io({a, 1'b0}, 1'b1, q, ack);
      `CHK("addr ack", 1'b0, ack)
      for (int i = 3; i >= 4 - n; i--) begin
         i_hsr_i2c_master.byte_io(d[8*i+:8], 1'b1, q, ack);
         `CHK("data ack", 1'b0, ack)
      end
      i_hsr_i2c_master.stop();
   endtask
   task automatic rd7(input logic [63:0] e);
      logic [7:0] q;
      logic ack;
      i_hsr_i2c_master.start();
      i_hsr_i2c_master.byte_io({DEF_ADDR, 1'b1}, 1'b1, q, ack);
      `CHK("addr ack", 1'b0, ack)
      for (int i = 7; i >= 0; i--) begin
         i_hsr_i2c_master.byte_io(8'hFF, i == 0, q, ack);
         `CHK("read byte", e[8*i+:8], q)
      end
      i_hsr_i2c_master.stop();
      repeat (300) @(negedge clk);
   endtask
   task automatic end_sim();
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // The span covers about a dozen frames at 400 kbit/s plus the waits.
   initial begin
      #(3_000_000);
      errors++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (60) @(negedge clk);
      rd7(64'h0);
      `CHK("starts", 0, n_start)
      wr(DEF_ADDR, 32'h0007_0000, 4);
      repeat (300) @(negedge clk);
      `CHK("frame", 2'h1, frame_count)
      rd7(img(2'h1));
      `CHK("starts", 8, n_start)
      `CHK("ints", 2, n_int)
      wake_en = 1'b1;
      thr_lo = {3{11'h400}};
      thr_hi = {3{11'h3FF}};
      wr(DEF_ADDR, 32'h0003_0000, 4);
      rd7(img(2'h2));
      `CHK("ints", 2, n_int)
      wr(7'h00, 32'h0, 0);
      repeat (20) @(negedge clk);
      `CHK("frame", 2'h0, frame_count)
      rd7(64'h0);
      thr_lo = {3{11'h738}};
      thr_hi = {3{11'h0C8}};
      wr(DEF_ADDR, 32'h0003_0000, 4);
      repeat (300) @(negedge clk);
      `CHK("ints", 3, n_int)
      supply_deep_low = 1'b1;
      repeat (5) @(negedge clk);
      supply_deep_low = 1'b0;
      repeat (5) @(negedge clk);
      `CHK("frame", 2'h0, frame_count)
      wr(DEF_ADDR, 32'h0003_0000, 4);
      wait (adc_chan === 2'h2);
      repeat (2) @(negedge clk);
      supply_ok = 1'b0;
      repeat (20) @(negedge clk);
      `CHK("starts", 19, n_start)
      `CHK("frame", 2'h0, frame_count)
      supply_ok = 1'b1;
      repeat (300) @(negedge clk);
      `CHK("starts", 23, n_start)
      `CHK("frame", 2'h1, frame_count)
      `CHK("ints", 4, n_int)
      // Fast mode converts many times inside one open write frame.
      int_inhibit_en = 1'b1;
      wr(DEF_ADDR, 32'h0002_0000, 4);
      wr(DEF_ADDR, 32'h0002_0000, 4);
      `CHK("ints", 4, n_int)
      end_sim();
   end
endmodule
`default_nettype wire
